// ### hdl/fan_alert.sv
// Functional notes
// - fan started from zero level runs top speed about one second, then programmed
// - spin-up timed by counter on oscillator enable, oscillator off when done
// - start: speed selects change first, shutdown released half interval later
// - zero level: shutdown asserted first, speed selects idle half interval later
// - oscillator powered down after the shutdown half interval
// - input pin changes set status regardless of enables and masks
// - status read returns bits then clears; repeats collapse to one bit
// - interrupt needs global interrupt enable set
// - interrupt also needs the pin's mask bit set
// - interrupt pulls alert low until alert response or status read
// - alert response releases alert; status stays until read
// - host may instead read status, clearing it and releasing alert
// - no status for output pins or upper four pins in fan mode
// - data stable while clock high; changes only while clock low
// - data fall with clock high is start, rise is stop
// - bus busy after start; free after stop or long idle high
// - bytes are eight bits msb first plus acknowledge bit
// - transmitter releases data at acknowledge; receiver pulls low to ack
// - reset: all inputs, open drain, data all ones, fan level zero
// - enabling fan mode with nonzero level starts spin-up; interrupts need the separate enable bit
// - fan mode: upper pins are speed selects two..zero and shutdown
// - answer alert response address while alert is asserted, with own address
`timescale 1ns/100ps
module fan_alert
  import fan_alert_pkg::*;
#(
  parameter int START_CNT = START_CYCLES
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic alert_n_o,
  output logic alert_oe_o,
  input wire logic [2:0] addr_strap_i,
  output logic osc_en_o
);
  localparam int HALF_CNT = START_CNT / 2;

  generate
    if (START_CNT < 2 || START_CNT >= (1 << CNT_W))
    begin : g_bad_start
      $error("START_CNT out of range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] device_config_r, direction_r, drive_style_r;
  logic [7:0] change_mask_r, out_data_r, fan_level_r, status_r;
  logic wr_en, rd_stat, fan_mode, irq_en;
  logic [2:0] idx;
  logic [7:0] wbyte;

  assign idx = adr_i[ADR_LSB+2:ADR_LSB];
  assign wbyte = dat_i[7:0];
  assign wr_en = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  assign rd_stat = cyc_i & stb_i & ~we_i & ~ack_o & (idx == IDX_STATUS);
  assign fan_mode = device_config_r[CFG_FAN_MODE_BIT];
  assign irq_en = device_config_r[CFG_IRQ_EN_BIT];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      device_config_r <= RST_DEVICE_CONFIG;
      direction_r <= RST_DIRECTION;
      drive_style_r <= RST_DRIVE_STYLE;
      change_mask_r <= RST_CHANGE_MASK;
      out_data_r <= RST_OUT_DATA;
      fan_level_r <= RST_FAN_LEVEL;
    end
    else if (wr_en)
    begin
      unique case (idx)
        IDX_DEVICE_CONFIG: device_config_r <= wbyte;
        IDX_DIRECTION: direction_r <= wbyte;
        IDX_DRIVE_STYLE: drive_style_r <= wbyte;
        IDX_CHANGE_MASK: change_mask_r <= wbyte;
        IDX_OUT_DATA: out_data_r <= wbyte;
        IDX_FAN_LEVEL: fan_level_r <= wbyte;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // wishbone answer: one wait state, unmapped reads zero
  // ---------------------------------------------------------------
  logic link_busy_r;
  logic [6:0] client_addr_r;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      dat_o <= 32'h0000_0000;
      if (cyc_i & stb_i & ~we_i & ~ack_o)
      begin
        unique case (idx)
          IDX_DEVICE_CONFIG: dat_o[7:0] <= device_config_r;
          IDX_DIRECTION: dat_o[7:0] <= direction_r;
          IDX_DRIVE_STYLE: dat_o[7:0] <= drive_style_r;
          IDX_STATUS: dat_o[7:0] <= status_r;
          IDX_CHANGE_MASK: dat_o[7:0] <= change_mask_r;
          IDX_OUT_DATA: dat_o[7:0] <= out_data_r;
          IDX_FAN_LEVEL: dat_o[7:0] <= fan_level_r;
          IDX_LINK_STATE: dat_o[7:0] <= {link_busy_r, client_addr_r};
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // input change capture
  // ---------------------------------------------------------------
  logic [7:0] pin_s1_r, pin_s2_r, pin_prev_r, watch, change;

  always_ff @(posedge clk_i)
  begin
    pin_s1_r <= pin_i;
    pin_s2_r <= pin_s1_r;
    pin_prev_r <= pin_s2_r;
  end

  always_comb
  begin
    watch = ~direction_r;
    if (fan_mode)
      watch[7:FAN_PIN_LO] = 4'h0;
  end

  assign change = (pin_s2_r ^ pin_prev_r) & watch;

  // unmaskable capture; set wins over read clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_r <= 8'h00;
    else if (rd_stat)
      status_r <= change;
    else
      status_r <= status_r | change;
  end

  // ---------------------------------------------------------------
  // alert
  // ---------------------------------------------------------------
  logic alert_r, irq_set, ara_done;

  assign irq_set = irq_en & |(change & change_mask_r);

  // held until released; release by response or read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      alert_r <= 1'b0;
    else if (irq_set)
      alert_r <= 1'b1;
    else if (rd_stat | ara_done)
      alert_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alert_n_o <= 1'b1;
      alert_oe_o <= 1'b0;
    end
    else
    begin
      alert_n_o <= 1'b0;
      alert_oe_o <= alert_r;
    end
  end

  // ---------------------------------------------------------------
  // fan sequencer
  // ---------------------------------------------------------------
  fan_state_t fan_st_r;
  logic [CNT_W-1:0] fan_cnt_r;
  logic [2:0] speed_select_n_r;
  logic fan_off_n_r, half_done, lvl_zero;

  assign half_done = (fan_cnt_r == CNT_W'(HALF_CNT - 1));
  assign lvl_zero = (fan_level_r == 8'h00);

  // counter advances only while the oscillator runs
  always_ff @(posedge clk_i)
  begin
    // shutdown during spin-up restarts the half interval
    if (rst_i || !osc_en_o || half_done || (lvl_zero && (fan_st_r == FAN_SPIN ||
        fan_st_r == FAN_BOOST)))
      fan_cnt_r <= '0;
    else
      fan_cnt_r <= fan_cnt_r + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !fan_mode)
      fan_st_r <= FAN_OFF;
    else
    begin
      unique case (fan_st_r)
        FAN_OFF: if (!lvl_zero) fan_st_r <= FAN_SPIN;
        FAN_SPIN:
          if (lvl_zero)
            fan_st_r <= FAN_STOP;
          else if (half_done)
            fan_st_r <= FAN_BOOST;
        FAN_BOOST:
          if (lvl_zero)
            fan_st_r <= FAN_STOP;
          else if (half_done)
            fan_st_r <= FAN_RUN;
        FAN_RUN: if (lvl_zero) fan_st_r <= FAN_STOP;
        FAN_STOP: if (half_done) fan_st_r <= FAN_OFF;
        default: fan_st_r <= FAN_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !fan_mode)
    begin
      speed_select_n_r <= SPEED_IDLE_N;
      fan_off_n_r <= 1'b0;
      osc_en_o <= 1'b0;
    end
    else
    begin
      unique case (fan_st_r)
        FAN_OFF:
        begin
          // speed selects move first, shutdown still held
          speed_select_n_r <= lvl_zero ? SPEED_IDLE_N : SPEED_TOP_N;
          fan_off_n_r <= 1'b0;
          osc_en_o <= !lvl_zero;
        end
        FAN_SPIN:
        begin
          speed_select_n_r <= SPEED_TOP_N;
          fan_off_n_r <= half_done & !lvl_zero;
          osc_en_o <= 1'b1;
        end
        FAN_BOOST:
        begin
          speed_select_n_r <= (half_done & !lvl_zero) ? ~fan_level_r[2:0] : SPEED_TOP_N;
          fan_off_n_r <= !lvl_zero;
          // oscillator off at end of interval
          osc_en_o <= lvl_zero | !half_done;
        end
        FAN_RUN:
        begin
          speed_select_n_r <= lvl_zero ? speed_select_n_r : ~fan_level_r[2:0];
          fan_off_n_r <= !lvl_zero;
          osc_en_o <= lvl_zero;
        end
        FAN_STOP:
        begin
          // selects idle after half interval; oscillator off
          speed_select_n_r <= half_done ? SPEED_IDLE_N : speed_select_n_r;
          fan_off_n_r <= 1'b0;
          osc_en_o <= !half_done;
        end
        default:
        begin
          speed_select_n_r <= SPEED_IDLE_N;
          fan_off_n_r <= 1'b0;
          osc_en_o <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  logic [7:0] drv_val, drv_oe;

  always_comb
  begin
    drv_val = out_data_r & direction_r & drive_style_r;
    drv_oe = direction_r & (drive_style_r | ~out_data_r);
    // fan pins open drain from the sequencer
    if (fan_mode)
    begin
      drv_val[7:FAN_PIN_LO] = 4'h0;
      drv_oe[7:FAN_PIN_LO] = ~{speed_select_n_r, fan_off_n_r};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_o <= 8'h00;
      pin_oe_o <= 8'h00;
    end
    else
    begin
      pin_o <= drv_val;
      pin_oe_o <= drv_oe;
    end
  end

  // ---------------------------------------------------------------
  // two-wire alert response slave
  // ---------------------------------------------------------------
  logic scl_s1_r, scl_s2_r, scl_prev_r, sda_s1_r, sda_s2_r, sda_prev_r;
  logic scl_rise, scl_fall, start_det, stop_det, strap_done_r;
  logic [$clog2(IDLE_CYCLES+1)-1:0] idle_cnt_r;
  link_state_t lnk_st_r;
  logic [7:0] sh_r;
  logic [3:0] bit_cnt_r;

  always_ff @(posedge clk_i)
  begin
    scl_s1_r <= scl_i;
    scl_s2_r <= scl_s1_r;
    scl_prev_r <= scl_s2_r;
    sda_s1_r <= sda_i;
    sda_s2_r <= sda_s1_r;
    sda_prev_r <= sda_s2_r;
  end

  assign scl_rise = scl_s2_r & ~scl_prev_r;
  assign scl_fall = ~scl_s2_r & scl_prev_r;
  // start and stop seen with clock high
  assign start_det = scl_s2_r & scl_prev_r & sda_prev_r & ~sda_s2_r;
  assign stop_det = scl_s2_r & scl_prev_r & ~sda_prev_r & sda_s2_r;

  // strap caught once after reset release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_done_r <= 1'b0;
      client_addr_r <= 7'h00;
    end
    else if (!strap_done_r)
    begin
      strap_done_r <= 1'b1;
      client_addr_r <= {CLIENT_ADDR_BASE, addr_strap_i};
    end
  end

  // busy from start until stop or idle high timeout
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      link_busy_r <= 1'b0;
      idle_cnt_r <= '0;
    end
    else
    begin
      if (!(scl_s2_r & sda_s2_r))
        idle_cnt_r <= '0;
      else if (idle_cnt_r != ($bits(idle_cnt_r))'(IDLE_CYCLES))
        idle_cnt_r <= idle_cnt_r + 1'b1;
      if (start_det)
        link_busy_r <= 1'b1;
      else if (stop_det || idle_cnt_r == ($bits(idle_cnt_r))'(IDLE_CYCLES))
        link_busy_r <= 1'b0;
    end
  end

  assign ara_done = (lnk_st_r == LNK_MACK) & scl_rise;

  always_ff @(posedge clk_i)
  begin
    // a start is taken in the same cycle that marks the bus busy
    if (rst_i || stop_det || !(link_busy_r || start_det))
    begin
      lnk_st_r <= LNK_IDLE;
      sda_oe_o <= 1'b0;
      sh_r <= 8'h00;
      bit_cnt_r <= 4'h0;
    end
    else if (start_det)
    begin
      lnk_st_r <= LNK_ADDR;
      sda_oe_o <= 1'b0;
      bit_cnt_r <= 4'h0;
    end
    else
    begin
      unique case (lnk_st_r)
        LNK_IDLE: ;
        LNK_ADDR:
          // eight bits msb first, sampled on clock rise
          if (scl_rise)
          begin
            sh_r <= {sh_r[6:0], sda_s2_r};
            bit_cnt_r <= bit_cnt_r + 1'b1;
          end
          else if (scl_fall && bit_cnt_r == 4'h8)
          begin
            // only while alert asserted; ack by pulling low
            if (sh_r == {ALERT_RESP_ADDR, 1'b1} && alert_r)
            begin
              lnk_st_r <= LNK_AACK;
              sda_oe_o <= 1'b1;
            end
            else
              lnk_st_r <= LNK_IDLE;
          end
        LNK_AACK:
          // data changes only after clock fall
          if (scl_fall)
          begin
            lnk_st_r <= LNK_SEND;
            sh_r <= {client_addr_r, 1'b0};
            sda_oe_o <= ~client_addr_r[6];
            bit_cnt_r <= 4'h0;
          end
        LNK_SEND:
          if (scl_rise)
          begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
            // lost arbitration to a lower address
            if (!sda_oe_o && !sda_s2_r)
              lnk_st_r <= LNK_IDLE;
          end
          else if (scl_fall)
          begin
            if (bit_cnt_r == 4'h8)
            begin
              // release data for the host acknowledge
              lnk_st_r <= LNK_MACK;
              sda_oe_o <= 1'b0;
            end
            else
            begin
              sh_r <= {sh_r[6:0], 1'b0};
              sda_oe_o <= ~sh_r[6];
            end
          end
        LNK_MACK: if (scl_rise) lnk_st_r <= LNK_IDLE;
        default: lnk_st_r <= LNK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    sda_o <= 1'b0;
  end
endmodule : fan_alert

// ### hdl/fan_alert_pkg.sv
package fan_alert_pkg;
  // ---------------------------------------------------------------
  // register indices; byte address is index times four
  // ---------------------------------------------------------------
  localparam logic [2:0] IDX_DEVICE_CONFIG = 3'h0;
  localparam logic [2:0] IDX_DIRECTION = 3'h1;
  localparam logic [2:0] IDX_DRIVE_STYLE = 3'h2;
  localparam logic [2:0] IDX_STATUS = 3'h3;
  localparam logic [2:0] IDX_CHANGE_MASK = 3'h4;
  localparam logic [2:0] IDX_OUT_DATA = 3'h5;
  localparam logic [2:0] IDX_FAN_LEVEL = 3'h6;
  localparam logic [2:0] IDX_LINK_STATE = 3'h7;
  localparam int ADR_LSB = 2;
  localparam int ADR_W = 5;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int CFG_FAN_MODE_BIT = 0;
  localparam int CFG_IRQ_EN_BIT = 1;
  localparam int FAN_PIN_LO = 4;
  localparam int FAN_OFF_PIN = 4;
  localparam logic [7:0] RST_DEVICE_CONFIG = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [7:0] RST_DRIVE_STYLE = 8'h00;
  localparam logic [7:0] RST_CHANGE_MASK = 8'h00;
  localparam logic [7:0] RST_OUT_DATA = 8'hFF;
  localparam logic [7:0] RST_FAN_LEVEL = 8'h00;
  localparam logic [2:0] SPEED_TOP_N = 3'h0;
  localparam logic [2:0] SPEED_IDLE_N = 3'h7;

  // ---------------------------------------------------------------
  // two-wire addresses
  // ---------------------------------------------------------------
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [3:0] CLIENT_ADDR_BASE = 4'h4;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int START_TIME_MS = 1000;
  localparam int START_CYCLES = START_TIME_MS * (CLK_HZ / 1000);
  localparam int IDLE_LIMIT_US = 50;
  localparam int IDLE_CYCLES = IDLE_LIMIT_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 25;

  typedef enum logic [2:0] {
    FAN_OFF = 3'b000,
    FAN_SPIN = 3'b001,
    FAN_BOOST = 3'b011,
    FAN_RUN = 3'b010,
    FAN_STOP = 3'b110
  } fan_state_t;

  typedef enum logic [2:0] {
    LNK_IDLE = 3'b000,
    LNK_ADDR = 3'b001,
    LNK_AACK = 3'b011,
    LNK_SEND = 3'b010,
    LNK_MACK = 3'b110
  } link_state_t;
endpackage : fan_alert_pkg

// ### tb/fan_alert_props.sv
`timescale 1ns/100ps
module fan_alert_props
  import fan_alert_pkg::*;
#(
  parameter int START_CNT = START_CYCLES
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic scl_i,
  input wire logic sda_oe_o,
  input wire logic alert_oe_o,
  input wire logic osc_en_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [31:0] osc_cnt_r;
  // ---------------------------------------------------------------
  // oscillator run length
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !osc_en_o)
      osc_cnt_r <= 32'h0000_0000;
    else
      osc_cnt_r <= osc_cnt_r + 32'h0000_0001;
  end
  sequence spin_release_s;
    osc_en_o && $fell(pin_oe_o[4]);
  endsequence
  sequence top_hold_s;
    (pin_oe_o[7:5] == 3'h7) [*8];
  endsequence
  sequence stop_begin_s;
    $rose(pin_oe_o[4]) && (pin_oe_o[7:5] != 3'h0);
  endsequence
  sequence select_hold_s;
    (pin_oe_o[7:5] != 3'h0) [*8];
  endsequence
  bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  read_idle_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  reset_state_a: assert property ($fell(rst_i) |-> pin_oe_o == 8'h00 && !alert_oe_o && !osc_en_o)
    else $error("outputs not idle after reset");
  spin_top_a: assert property (spin_release_s |-> top_hold_s)
    else $error("top speed not held after shutdown release");
  stop_order_a: assert property (stop_begin_s |=> select_hold_s)
    else $error("speed selects dropped with shutdown");
  osc_limit_a: assert property (osc_cnt_r <= START_CNT + 2)
    else $error("oscillator left running");
  alert_clear_a: assert property ($fell(alert_oe_o) |->
    $past(ack_o) || ($past(scl_i, 4) && !$past(scl_i, 5)))
    else $error("alert released without read or response");
  ara_gate_a: assert property ($rose(sda_oe_o) |-> alert_oe_o)
    else $error("data line driven without alert");
  sda_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed while clock high");
endmodule : fan_alert_props
bind fan_alert fan_alert_props #(.START_CNT(START_CNT)) props (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .dat_o(dat_o), .pin_oe_o(pin_oe_o),
  .scl_i(scl_i), .sda_oe_o(sda_oe_o), .alert_oe_o(alert_oe_o), .osc_en_o(osc_en_o));

// ### tb/smbus_host.sv
`timescale 1ns/100ps
module smbus_host
  import fan_alert_pkg::*;
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic half_bit;
    repeat (4) @(posedge clk_i);
  endtask : half_bit
  task automatic put_bit(input logic b, output logic r);
    @(posedge clk_i);
    sda_low_o <= ~b;
    repeat (3) @(posedge clk_i);
    scl_o <= 1'b1;
    half_bit();
    r = sda_i;
    scl_o <= 1'b0;
  endtask : put_bit
  task automatic ara_read(output logic acked, output logic [7:0] data);
    logic r;
    logic [7:0] addr_rd;
    addr_rd = {ALERT_RESP_ADDR, 1'b1};
    @(posedge clk_i);
    sda_low_o <= 1'b1;
    half_bit();
    scl_o <= 1'b0;
    for (int i = 7; i >= 0; i--)
      put_bit(addr_rd[i], r);
    put_bit(1'b1, r);
    acked = ~r;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, r);
      data[i] = r;
    end
    put_bit(1'b0, r);
    @(posedge clk_i);
    sda_low_o <= 1'b1;
    half_bit();
    scl_o <= 1'b1;
    half_bit();
    sda_low_o <= 1'b0;
  endtask : ara_read
endmodule : smbus_host

// ### tb/test_fan_sequencer_and_input_alert.sv
`timescale 1ns/100ps
module test_fan_sequencer_and_input_alert
  import fan_alert_pkg::*;
;
  localparam int HALF = 20;
  localparam logic [7:0] RST_TAB [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
  logic clk;
  logic rst;
  logic cyc;
  logic stb;
  logic we;
  logic [ADR_W-1:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] ext;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic sda_out;
  logic sda_oe;
  logic alert_n;
  logic alert_oe;
  logic osc_en;
  logic scl;
  logic sda_low;
  logic acked;
  logic [7:0] ara_data;
  wire logic [7:0] pin_lvl;
  wire logic sda_lvl;
  int failures;
  int comparisons;
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext);
  assign sda_lvl = ~((sda_oe & ~sda_out) | sda_low);
  fan_alert #(.START_CNT(2 * HALF)) dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .pin_i(pin_lvl), .pin_o(pin_out), .pin_oe_o(pin_oe), .scl_i(scl), .sda_i(sda_lvl),
    .sda_o(sda_out), .sda_oe_o(sda_oe), .alert_n_o(alert_n), .alert_oe_o(alert_oe),
    .addr_strap_i(3'h5), .osc_en_o(osc_en));
  smbus_host host (.clk_i(clk), .sda_i(sda_lvl), .scl_o(scl), .sda_low_o(sda_low));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // access and check tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [2:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx, 2'h0};
    wdat <= {24'h00_0000, d};
    sel <= 4'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    if (n >= 20)
    begin
      failures++;
      $display("wrong value at %0t: no bus answer", $time);
      end_of_test();
    end
  endtask : bus
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr
  task automatic rd(input logic [2:0] idx, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, {24'h00_0000, exp});
  endtask : rd
  task automatic flip(input logic [7:0] m);
    ext <= ext ^ m;
    repeat (8) @(posedge clk);
  endtask : flip
  task automatic fan_wait(input logic [4:0] st, input int lo, input int hi);
    int n;
    n = 0;
    while ({pin_oe[7:4], osc_en} !== st && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 200)
    begin
      failures++;
      $display("wrong value at %0t: fan state not reached", $time);
      end_of_test();
    end
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask : fan_wait
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    failures = 0;
    comparisons = 0;
    rst = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    ext = 8'hFF;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++)
      rd(3'(i), RST_TAB[i]);
    chk(32'(pin_oe), 32'h0000_0000);
    chk(32'({alert_n, sda_out}), 32'h0000_0000);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h25);
    flip(8'h09);
    flip(8'h08);
    rd(3'h3, 8'h09);
    rd(3'h3, 8'h00);
    wr(3'h1, 8'h02);
    flip(8'h02);
    rd(3'h3, 8'h00);
    wr(3'h2, 8'h02);
    chk(32'({pin_oe, pin_out}), 32'h0000_0202);
    rd(3'h3, 8'h00);
    wr(3'h4, 8'h01);
    flip(8'h01);
    chk(32'(alert_oe), 32'h0000_0000);
    rd(3'h3, 8'h01);
    wr(3'h0, 8'h02);
    flip(8'h04);
    chk(32'(alert_oe), 32'h0000_0000);
    rd(3'h3, 8'h04);
    flip(8'h01);
    repeat (20) @(posedge clk);
    chk(32'(alert_oe), 32'h0000_0001);
    rd(3'h3, 8'h01);
    chk(32'(alert_oe), 32'h0000_0000);
    host.ara_read(acked, ara_data);
    chk(32'(acked), 32'h0000_0000);
    flip(8'h01);
    host.ara_read(acked, ara_data);
    chk(32'(acked), 32'h0000_0001);
    chk(32'(ara_data), 32'h0000_004A);
    chk(32'(alert_oe), 32'h0000_0000);
    rd(3'h3, 8'h01);
    wr(3'h5, 8'hFF);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'h02);
    wr(3'h6, 8'h05);
    wr(3'h4, 8'h01);
    rd(3'h3, 8'h00);
    wr(3'h0, 8'h03);
    fan_wait(5'h1F, 0, 4);
    fan_wait(5'h1D, HALF - 3, HALF + 3);
    fan_wait(5'h14, HALF - 3, HALF + 3);
    flip(8'h40);
    rd(3'h3, 8'h00);
    wr(3'h6, 8'h00);
    fan_wait(5'h17, 0, 4);
    fan_wait(5'h02, HALF - 3, HALF + 3);
    end_of_test();
  end
endmodule : test_fan_sequencer_and_input_alert
